// ===== core/pdh_pkg.sv
// Shared constants and types for the palette DAC host port and pixel control
package pdh_pkg;

    // ==========================================================
    // Register select encoding
    localparam logic [2:0] RS_ADDR_WR     = 3'h0;
    localparam logic [2:0] RS_PAL_DATA    = 3'h1;
    localparam logic [2:0] RS_MASK        = 3'h2;
    localparam logic [2:0] RS_ADDR_RD     = 3'h3;
    localparam logic [2:0] RS_OVL_ADDR_WR = 3'h4;
    localparam logic [2:0] RS_OVL_DATA    = 3'h5;
    localparam logic [2:0] RS_CTRL        = 3'h6;
    localparam logic [2:0] RS_OVL_ADDR_RD = 3'h7;

    // ==========================================================
    // Control register fields
    localparam int SLEEP_BIT             = 0;
    localparam int RESOLUTION_SELECT_BIT = 1;
    localparam int SYNC_CHANNEL_LO       = 2;
    localparam int SYNC_CHANNEL_HI       = 4;
    localparam int COLOR_MODE_LO         = 5;
    localparam int COLOR_MODE_MSB        = 7;

    // ==========================================================
    // Colour modes
    localparam logic [2:0] MODE_PSEUDO  = 3'h0;
    localparam logic [2:0] MODE_TC15    = 3'h1;
    localparam logic [2:0] MODE_TC24    = 3'h2;
    localparam logic [2:0] MODE_TC16    = 3'h3;
    localparam logic [2:0] MODE_BP15_1  = 3'h4;
    localparam logic [2:0] MODE_BP15    = 3'h5;
    localparam logic [2:0] MODE_BP16    = 3'h6;
    localparam logic [2:0] MODE_BP24    = 3'h7;

    // ==========================================================
    // Phases, seeds and misc values
    localparam logic [1:0] PH_RED     = 2'h0;
    localparam logic [1:0] PH_GREEN   = 2'h1;
    localparam logic [1:0] PH_BLUE    = 2'h2;
    localparam logic [1:0] CLK_ONE    = 2'h0;
    localparam logic [1:0] CLK_TWO    = 2'h1;
    localparam logic [1:0] CLK_THREE  = 2'h2;
    localparam logic [1:0] MASK_READS_LAST = 2'h3;
    localparam logic [7:0] SIG_SEED   = 8'hAA;
    localparam logic [7:0] PTR_STEP   = 8'h01;
    localparam logic [3:0] OVL_SIG    = 4'h0;
    localparam int FIFO_DEPTH = 16;
    localparam int PAL_DEPTH  = 256;
    localparam int OVL_DEPTH  = 16;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } pdh_rgb_t;

    typedef struct packed {
        pdh_rgb_t   color;
        logic       active;
        logic [2:0] sync_rgb;
    } pdh_video_t;

    typedef struct packed {
        logic [2:0] rs;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] data;
    } pdh_host_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mask;
        logic [7:0] ptr;
        logic [1:0] phase;
        logic       rd_mode;
        logic       ovl_mode;
        pdh_rgb_t   hold;
        logic [1:0] mask_reads;
        logic       redirect;
        logic       rd_prev;
        logic       wr_prev;
        logic [7:0] rdata;
        logic       oe;
        logic [1:0] pcnt;
        logic [7:0] byte0;
        logic [7:0] byte1;
        pdh_rgb_t   pix_color;
        pdh_rgb_t   sig;
    } pdh_state_t;

endpackage

// ===== core/pdh_sync.sv
// Two-stage synchroniser for the asynchronous host pins
`timescale 1ns/1ps
module pdh_sync
    import pdh_pkg::*;
#(
    parameter int               WIDTH     = 13,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Stage 0 feeds only stage 1
    logic [1:0][WIDTH-1:0] stage_q;
    logic [1:0][WIDTH-1:0] stage_d;

    always_comb begin
        stage_d = {stage_q[0], async_in};
        if (srst) begin
            stage_d = {RESET_VAL, RESET_VAL};
        end
    end

    always_ff @(posedge core_clk) begin
        stage_q <= stage_d;
    end

    assign sync_out = stage_q[1];

endmodule

// ===== core/pdh_fifo.sv
// Parameterised FIFO for the video output stream
`timescale 1ns/1ps
module pdh_fifo
    import pdh_pkg::*;
#(
    parameter int WIDTH = 28,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } pdh_fifo_state_t;

    // ==========================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    pdh_fifo_state_t  st_q;
    pdh_fifo_state_t  st_d;
    logic             push;
    logic             pop;

    assign in_ready  = (st_q.count != (AW+1)'(DEPTH));
    assign out_valid = (st_q.count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr_ptr = (st_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(st_q.wr_ptr + 1'b1);
        end
        if (pop) begin
            st_d.rd_ptr = (st_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(st_q.rd_ptr + 1'b1);
        end
        if (push && !pop) begin
            st_d.count = (AW+1)'(st_q.count + 1'b1);
        end else if (pop && !push) begin
            st_d.count = (AW+1)'(st_q.count - 1'b1);
        end
        if (srst) begin
            st_d = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
        if (push && !srst) begin
            mem[st_q.wr_ptr] <= in_data;
        end
    end

    // Data output is the unregistered array word at the read pointer
    assign out_data = mem[st_q.rd_ptr];

endmodule

// ===== core/pdh_palette_dac_ctrl.sv
// Host port, palette, overlay and pixel control logic of the palette DAC
`timescale 1ns/1ps
module pdh_palette_dac_ctrl
    import pdh_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic [2:0] register_select_lines,
    input  wire logic       host_rd_n,
    input  wire logic       host_wr_n,
    input  wire logic [7:0] host_data_in,
    output logic      [7:0] host_data_out,
    output logic            host_data_oe,
    input  wire logic       true_color_select_pin,
    input  wire logic       res_select_pin,
    input  wire logic [7:0] pixel_in,
    input  wire logic [7:0] pixel_msb_in,
    input  wire logic [3:0] overlay_code_pins,
    input  wire logic       blank_n,
    input  wire logic       sync_n,
    output logic            pixel_in_ready,
    output logic            video_valid,
    input  wire logic       video_ready,
    output pdh_video_t      video_out,
    output logic            dac_sleep
);

    // ==========================================================
    // Host pin synchroniser
    pdh_host_t  host_raw;
    pdh_host_t  hs;

    assign host_raw = '{rs: register_select_lines, rd_n: host_rd_n, wr_n: host_wr_n, data: host_data_in};

    pdh_sync #(
        .WIDTH     ($bits(pdh_host_t)),
        .RESET_VAL ({3'h0, 1'b1, 1'b1, 8'h00})
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (host_raw),
        .sync_out (hs)
    );

    // ==========================================================
    // Memories and state
    pdh_rgb_t   pal_mem [PAL_DEPTH];
    pdh_rgb_t   ovl_mem [OVL_DEPTH];
    pdh_state_t st_q;
    pdh_state_t st_d;
    logic       pal_we;
    logic       ovl_we;
    pdh_rgb_t   mem_wdata;
    pdh_video_t vid;

    // Overlay index 0 is the signature path, not storage
    function automatic pdh_rgb_t fetch_entry(input logic ovl, input logic [7:0] addr, input pdh_rgb_t sig);
        if (!ovl) begin
            return pal_mem[addr];
        end
        if (addr[3:0] == OVL_SIG) begin
            return sig;
        end
        return ovl_mem[addr[3:0]];
    endfunction

    function automatic logic [1:0] last_phase(input logic [2:0] mode);
        case (mode)
            MODE_PSEUDO, MODE_BP15_1: return CLK_ONE;
            MODE_TC24, MODE_BP24:     return CLK_THREE;
            default:                  return CLK_TWO;
        endcase
    endfunction

    // Assembled pixel field to colour; 5/6 bit fields pad their LSBs with zero
    function automatic pdh_rgb_t decode(input logic [2:0] mode, input logic [23:0] f);
        pdh_rgb_t c;
        c = '0;
        case (mode)
            MODE_PSEUDO: c = pal_mem[f[7:0]];
            MODE_TC15: begin
                c.r = pal_mem[{f[14:10], 3'h0}].r;
                c.g = pal_mem[{f[9:5], 3'h0}].g;
                c.b = pal_mem[{f[4:0], 3'h0}].b;
            end
            MODE_TC16: begin
                c.r = pal_mem[{f[15:11], 3'h0}].r;
                c.g = pal_mem[{f[10:5], 2'h0}].g;
                c.b = pal_mem[{f[4:0], 3'h0}].b;
            end
            MODE_TC24: begin
                c.r = pal_mem[f[23:16]].r;
                c.g = pal_mem[f[15:8]].g;
                c.b = pal_mem[f[7:0]].b;
            end
            MODE_BP15_1, MODE_BP15: c = '{r: {f[14:10], 3'h0}, g: {f[9:5], 3'h0}, b: {f[4:0], 3'h0}};
            MODE_BP16:   c = '{r: {f[15:11], 3'h0}, g: {f[10:5], 2'h0}, b: {f[4:0], 3'h0}};
            MODE_BP24:   c = f;
            default:     c = '0;
        endcase
        return c;
    endfunction

    // ==========================================================
    // Next state
    logic       rd_fall;
    logic       rd_rise;
    logic       wr_rise;
    logic       eight_bit;
    logic [2:0] color_mode;
    logic       bypass;
    logic       ovl_enable;
    logic       last;
    logic [7:0] pix_m;
    logic [7:0] wbyte;
    logic [23:0] field;
    pdh_rgb_t   new_color;
    logic       mask_target;

    always_comb begin
        st_d        = st_q;
        pal_we      = 1'b0;
        ovl_we      = 1'b0;
        mem_wdata   = '0;
        rd_fall     = st_q.rd_prev & ~hs.rd_n;
        rd_rise     = ~st_q.rd_prev & hs.rd_n;
        wr_rise     = ~st_q.wr_prev & hs.wr_n;
        st_d.rd_prev = hs.rd_n;
        st_d.wr_prev = hs.wr_n;
        eight_bit   = st_q.ctrl[RESOLUTION_SELECT_BIT] | res_select_pin;
        wbyte       = eight_bit ? hs.data : {hs.data[5:0], 2'h0};
        mask_target = (hs.rs == RS_MASK);

        // Pixel path
        color_mode = true_color_select_pin ? st_q.ctrl[COLOR_MODE_MSB:COLOR_MODE_LO]
                                           : overlay_code_pins[3:1];
        bypass     = color_mode[2];
        ovl_enable = true_color_select_pin & ~bypass & (overlay_code_pins != 4'h0);
        pix_m      = bypass ? pixel_in : (pixel_in & st_q.mask);
        last       = (st_q.pcnt == last_phase(color_mode));
        case (last_phase(color_mode))
            CLK_ONE:   field = (color_mode == MODE_BP15_1) ? {8'h00, pixel_msb_in, pixel_in} : {16'h0000, pix_m};
            CLK_TWO:   field = {8'h00, pix_m, st_q.byte0};
            default:   field = {pix_m, st_q.byte1, st_q.byte0};
        endcase
        new_color = decode(color_mode, field);
        if (!blank_n) begin
            st_d.pcnt = CLK_ONE;
        end else begin
            if (st_q.pcnt == CLK_ONE) begin
                st_d.byte0 = pix_m;
            end
            if (st_q.pcnt == CLK_TWO) begin
                st_d.byte1 = pix_m;
            end
            if (last) begin
                st_d.pcnt      = CLK_ONE;
                st_d.pix_color = new_color;
                st_d.sig.r = {st_q.sig.r[6:0], st_q.sig.r[7]} ^ new_color.r;
                st_d.sig.g = {st_q.sig.g[6:0], st_q.sig.g[7]} ^ new_color.g;
                st_d.sig.b = {st_q.sig.b[6:0], st_q.sig.b[7]} ^ new_color.b;
            end else begin
                st_d.pcnt = 2'(st_q.pcnt + 2'h1);
            end
        end

        // Host read: data is driven from the falling strobe, effects land on release
        if (rd_fall) begin
            st_d.oe = 1'b1;
            case (hs.rs)
                RS_PAL_DATA, RS_OVL_DATA: begin
                    case (st_q.phase)
                        PH_RED:   st_d.rdata = st_q.hold.r;
                        PH_GREEN: st_d.rdata = st_q.hold.g;
                        default:  st_d.rdata = st_q.hold.b;
                    endcase
                    if (!eight_bit) begin
                        st_d.rdata = {2'h0, st_d.rdata[7:2]};
                    end
                end
                RS_MASK:  st_d.rdata = st_q.redirect ? st_q.ctrl : st_q.mask;
                RS_CTRL:  st_d.rdata = st_q.ctrl;
                default:  st_d.rdata = st_q.ptr;
            endcase
        end
        if (rd_rise) begin
            st_d.oe = 1'b0;
            if (mask_target) begin
                if (st_q.redirect) begin
                    st_d.redirect = 1'b0;
                end else if (st_q.mask_reads == MASK_READS_LAST) begin
                    st_d.redirect   = 1'b1;
                    st_d.mask_reads = 2'h0;
                end else begin
                    st_d.mask_reads = 2'(st_q.mask_reads + 2'h1);
                end
            end else begin
                st_d.redirect   = 1'b0;
                st_d.mask_reads = 2'h0;
            end
            if (hs.rs == RS_PAL_DATA || hs.rs == RS_OVL_DATA) begin
                if (st_q.phase == PH_BLUE) begin
                    st_d.phase = PH_RED;
                    st_d.hold  = fetch_entry(st_q.ovl_mode, st_q.ptr, st_q.sig);
                    st_d.ptr   = 8'(st_q.ptr + PTR_STEP);
                end else begin
                    st_d.phase = 2'(st_q.phase + 2'h1);
                end
            end
        end

        // Host write, taken on release of the strobe
        if (wr_rise) begin
            st_d.redirect   = 1'b0;
            st_d.mask_reads = 2'h0;
            if (!mask_target) begin
                st_d.redirect = 1'b0;
            end
            case (hs.rs)
                RS_ADDR_WR, RS_ADDR_RD, RS_OVL_ADDR_WR, RS_OVL_ADDR_RD: begin
                    st_d.ptr      = hs.data;
                    st_d.phase    = PH_RED;
                    st_d.rd_mode  = hs.rs[0] & hs.rs[1];
                    st_d.ovl_mode = hs.rs[2];
                    if (hs.rs[0] & hs.rs[1]) begin
                        st_d.hold = fetch_entry(hs.rs[2], hs.data, st_q.sig);
                        st_d.ptr  = 8'(hs.data + PTR_STEP);
                    end
                end
                RS_PAL_DATA, RS_OVL_DATA: begin
                    case (st_q.phase)
                        PH_RED: begin
                            st_d.hold.r = wbyte;
                            st_d.phase  = PH_GREEN;
                        end
                        PH_GREEN: begin
                            st_d.hold.g = wbyte;
                            st_d.phase  = PH_BLUE;
                        end
                        default: begin
                            mem_wdata  = '{r: st_q.hold.r, g: st_q.hold.g, b: wbyte};
                            pal_we     = ~hs.rs[2];
                            ovl_we     = hs.rs[2] & (st_q.ptr[3:0] != OVL_SIG);
                            st_d.phase = PH_RED;
                            st_d.ptr   = 8'(st_q.ptr + PTR_STEP);
                        end
                    endcase
                    if (hs.rs[2] && st_q.ptr[3:0] == OVL_SIG) begin
                        st_d.sig = '{r: SIG_SEED, g: SIG_SEED, b: SIG_SEED};
                    end
                end
                RS_MASK: begin
                    if (st_q.redirect) begin
                        st_d.ctrl = hs.data;
                    end else begin
                        st_d.mask = hs.data;
                    end
                end
                default: st_d.ctrl = hs.data;
            endcase
        end

        // Control and mask keep their contents through reset
        if (srst) begin
            st_d         = '0;
            st_d.ctrl    = st_q.ctrl;
            st_d.mask    = st_q.mask;
            st_d.rd_prev = 1'b1;
            st_d.wr_prev = 1'b1;
            pal_we       = 1'b0;
            ovl_we       = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
        if (pal_we) begin
            pal_mem[st_q.ptr] <= mem_wdata;
        end
        if (ovl_we) begin
            ovl_mem[st_q.ptr[3:0]] <= mem_wdata;
        end
    end

    // ==========================================================
    // Video stream: one word per clock, overlay checked on every edge
    always_comb begin
        vid        = '0;
        vid.active = blank_n;
        if (blank_n) begin
            vid.color = ovl_enable ? ovl_mem[overlay_code_pins]
                                   : (last ? new_color : st_q.pix_color);
        end
        vid.sync_rgb = sync_n ? 3'h0 : st_q.ctrl[SYNC_CHANNEL_HI:SYNC_CHANNEL_LO];
    end

    pdh_fifo #(
        .WIDTH ($bits(pdh_video_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (~srst),
        .in_ready  (pixel_in_ready),
        .in_data   (vid),
        .out_valid (video_valid),
        .out_ready (video_ready),
        .out_data  (video_out)
    );

    // Sleep lifts while a strobe is low so palette updates still land
    assign dac_sleep     = st_q.ctrl[SLEEP_BIT] & hs.rd_n & hs.wr_n;
    assign host_data_out = st_q.rdata;
    assign host_data_oe  = st_q.oe;

endmodule

// ===== sim/pdh_ctrl_asserts.sv
// Port-level checker for the palette DAC host port and video stream
`timescale 1ns/1ps
module pdh_ctrl_asserts
    import pdh_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       srst,
    input wire logic       host_rd_n,
    input wire logic       host_wr_n,
    input wire logic [7:0] host_data_out,
    input wire logic       host_data_oe,
    input wire logic       pixel_in_ready,
    input wire logic       video_valid,
    input wire logic       video_ready,
    input wire pdh_video_t video_out,
    input wire logic       dac_sleep
);
    // ==========================================================
    // Host port timing, two-flop synchroniser plus one register
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sleep_wake_a: assert property (dac_sleep |-> $past(host_rd_n, 2) && $past(host_wr_n, 2))
        else $error("sleep held during a host strobe");
    oe_rise_a: assert property ($fell(host_rd_n) |-> ##3 host_data_oe)
        else $error("read data not driven three clocks after strobe");
    oe_fall_a: assert property ($rose(host_rd_n) |-> ##3 !host_data_oe)
        else $error("read data still driven after strobe release");
    oe_cause_a: assert property (host_data_oe |-> !$past(host_rd_n, 3))
        else $error("data bus driven without a read");
    rdata_hold_a: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
        else $error("read data changed during a read");
    reset_quiet_a: assert property ($fell(srst) |-> !host_data_oe && !video_valid)
        else $error("outputs active right after reset");
    // ==========================================================
    // Video stream buffer
    full_not_empty_a: assert property (!pixel_in_ready |-> video_valid)
        else $error("buffer refuses while empty");
    video_hold_a: assert property (video_valid && !video_ready |=> video_valid && $stable(video_out))
        else $error("video word lost during stall");
endmodule

bind pdh_palette_dac_ctrl pdh_ctrl_asserts u_chk (
    .core_clk(core_clk), .srst(srst), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .pixel_in_ready(pixel_in_ready),
    .video_valid(video_valid), .video_ready(video_ready), .video_out(video_out), .dac_sleep(dac_sleep)
);

// ===== sim/pdh_host_model.sv
// Behavioural host processor on the parallel register port
`timescale 1ns/1ps
module pdh_host_model
    import pdh_pkg::*;
(
    input  wire logic       core_clk,
    output logic      [2:0] rs,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    // ==========================================================
    // Strobe cycles
    initial begin
        rs = RS_ADDR_WR;
        rd_n = 1'b1;
        wr_n = 1'b1;
        wdata = 8'h00;
    end

    // Five clocks low and high, above the three the synchroniser and edge register need
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        @(posedge core_clk) #1;
        rs = sel;
        wdata = d;
        wr_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 wr_n = 1'b1;
        repeat (5) @(posedge core_clk);
        // Released bus must not keep showing the written byte
        #1 wdata = ~d;
    endtask

    task automatic rd(input logic [2:0] sel, output logic [7:0] d);
        @(posedge core_clk) #1;
        rs = sel;
        rd_n = 1'b0;
        repeat (5) @(posedge core_clk);
        d = rdata;
        #1 rd_n = 1'b1;
        repeat (5) @(posedge core_clk);
        // Return off the edge so the caller never drives pins in the sampling step
        #1;
    endtask
endmodule

// ===== sim/pdh_palette_dac_ctrl_bench.sv
// Self-checking bench for the palette DAC host port and pixel control
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module pdh_palette_dac_ctrl_bench;
    import pdh_pkg::*;
    logic       core_clk, srst, rd_n, wr_n, oe, tc_pin, blank_n, sync_n, pin_rdy, vvalid, video_ready, sleep;
    logic [2:0] rs;
    logic [7:0] wdata, rdata, pixel, d;
    logic [3:0] ovl;
    logic       res_pin;
    pdh_video_t vout;
    int         failures = 0;
    int         tests_run = 0;

    pdh_palette_dac_ctrl #(.DEPTH(FIFO_DEPTH)) dut (
        .core_clk(core_clk), .srst(srst), .register_select_lines(rs), .host_rd_n(rd_n), .host_wr_n(wr_n),
        .host_data_in(wdata), .host_data_out(rdata), .host_data_oe(oe), .true_color_select_pin(tc_pin),
        .res_select_pin(res_pin), .pixel_in(pixel), .pixel_msb_in(8'h00), .overlay_code_pins(ovl),
        .blank_n(blank_n), .sync_n(sync_n), .pixel_in_ready(pin_rdy), .video_valid(vvalid),
        .video_ready(video_ready), .video_out(vout), .dac_sleep(sleep)
    );
    pdh_host_model host (.core_clk(core_clk), .rs(rs), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ==========================================================
    // Helpers
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rchk(input logic [2:0] sel, input logic [7:0] ex);
        host.rd(sel, d);
        `CHK("host read", ex, d)
    endtask
    // Drain path is short with the sink always ready, so six clocks suffice
    task automatic vchk(input logic [23:0] ex);
        settle(6);
        `CHK("colour", ex, vout.color)
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_ctrl;
        host.wr(RS_CTRL, 8'h5B);
        settle(2);
        `CHK("sleep", 1'h1, sleep)
        rchk(RS_CTRL, 8'h5B);
        host.wr(RS_CTRL, 8'h12);
        `CHK("sleep", 1'h0, sleep)
    endtask
    task automatic t_pal;
        host.wr(RS_ADDR_WR, 8'hFF);
        for (int i = 1; i < 4; i++) begin
            host.wr(RS_PAL_DATA, 8'(i * 17));
        end
        rchk(RS_ADDR_WR, 8'h00);
        host.wr(RS_ADDR_RD, 8'hFF);
        rchk(RS_ADDR_RD, 8'h00);
        for (int i = 1; i < 4; i++) begin
            rchk(RS_PAL_DATA, 8'(i * 17));
        end
        rchk(RS_ADDR_RD, 8'h01);
        // Partial triplet then a new address must restart at red
        host.wr(RS_ADDR_WR, 8'h10);
        host.wr(RS_PAL_DATA, 8'h77);
        host.wr(RS_ADDR_WR, 8'h05);
        for (int i = 1; i < 4; i++) begin
            host.wr(RS_PAL_DATA, 8'(i));
        end
    endtask
    task automatic t_mask;
        host.wr(RS_MASK, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            rchk(RS_MASK, 8'h0F);
        end
        host.wr(RS_MASK, 8'h16);
        rchk(RS_CTRL, 8'h16);
        rchk(RS_MASK, 8'h0F);
        // That read counts, so three more make four in a row
        for (int i = 0; i < 3; i++) begin
            rchk(RS_MASK, 8'h0F);
        end
        rchk(RS_ADDR_WR, 8'h06);
        rchk(RS_MASK, 8'h0F);
        for (int i = 0; i < 3; i++) begin
            rchk(RS_MASK, 8'h0F);
        end
        rchk(RS_MASK, 8'h16);
        rchk(RS_MASK, 8'h0F);
    endtask
    task automatic t_sig;
        // Blanking is held throughout these accesses; control bit 1 low so the pin decides width
        host.wr(RS_CTRL, 8'h14);
        host.wr(RS_OVL_ADDR_WR, 8'h00);
        host.wr(RS_OVL_DATA, 8'h55);
        host.wr(RS_OVL_ADDR_RD, 8'h00);
        res_pin = 1'b1;
        rchk(RS_OVL_DATA, SIG_SEED);
        res_pin = 1'b0;
        rchk(RS_OVL_DATA, 8'(SIG_SEED >> 2));
        res_pin = 1'b1;
        rchk(RS_OVL_DATA, SIG_SEED);
    endtask
    task automatic t_video;
        tc_pin = 1'b0;
        host.wr(RS_OVL_ADDR_WR, 8'h01);
        for (int i = 0; i < 3; i++) begin
            host.wr(RS_OVL_DATA, 8'(10 + i));
        end
        settle(1);
        pixel = 8'hF5;
        ovl = 4'hC;
        blank_n = 1'b1;
        sync_n = 1'b0;
        // Pins pick the 5-6-5 bypass mode while the control field says pseudocolour
        vchk(24'hF0BCA8);
        `CHK("sync", 3'h5, vout.sync_rgb)
        tc_pin = 1'b1;
        ovl = 4'h1;
        vchk(24'h0A0B0C);
        ovl = 4'h0;
        vchk(24'h010203);
        host.wr(RS_CTRL, 8'hF6);
        ovl = 4'h1;
        vchk(24'hF5F5F5);
        video_ready = 1'b0;
        settle(24);
        `CHK("in ready", 1'h0, pin_rdy)
        `CHK("out valid", 1'h1, vvalid)
        video_ready = 1'b1;
        settle(3);
        `CHK("in ready", 1'h1, pin_rdy)
    endtask

    initial begin
        srst = 1'b1;
        tc_pin = 1'b1;
        blank_n = 1'b0;
        sync_n = 1'b1;
        pixel = 8'h00;
        ovl = 4'h0;
        res_pin = 1'b0;
        video_ready = 1'b1;
        settle(10);
        srst = 1'b0;
        settle(3);
        t_ctrl();
        t_pal();
        t_mask();
        t_sig();
        t_video();
        print_verdict();
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        print_verdict();
    end
endmodule
